// file: core/samc_pkg.sv
// package for the supply aware mode control block
// assumes one 20 MHz clock and pre-comparated supply level inputs
package samc_pkg;
    localparam int CLK_FREQ_HZ = 20_000_000;
    localparam int NUM_CHANNELS = 8;
    localparam int NUM_INPUTS = 2;
    // serial clock ceilings in MHz, zero means no serial access
    localparam logic [2:0] SCLK_LIMIT_NONE_MHZ = 3'h0;
    localparam logic [2:0] SCLK_LIMIT_LOW_MHZ = 3'h1;
    localparam logic [2:0] SCLK_LIMIT_FULL_MHZ = 3'h5;
    // mode transition latency, in ns as figure, then derived cycles
    localparam int MODE_DELAY_NS = 200;
    localparam int MODE_DELAY_CYC =
        (MODE_DELAY_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] MODE_DELAY_CNT = 4'(MODE_DELAY_CYC);
    // reset values
    localparam logic [NUM_CHANNELS-1:0] CHAN_RESET = 8'h00;
    // default input to channel mapping: input 0 to ch2, input 1 to ch3
    localparam logic [NUM_CHANNELS-1:0] IN0_DEFAULT_MAP = 8'h04;
    localparam logic [NUM_CHANNELS-1:0] IN1_DEFAULT_MAP = 8'h08;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_IDLE,
        MODE_ACTIVE,
        MODE_LIMP
    } samc_mode_t;
endpackage : samc_pkg

// file: core/samc_sync.sv
// three flop synchroniser with agreement filter for one pin level
// assumes pin is asynchronous to ref_clk
`timescale 1ns/10ps
module samc_sync
    import samc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    // level only moves once the second and third stages agree
    always_comb
    begin
        next_level = level;
        if (s2 == s3)
            next_level = s3;
    end

    // s1 is read only by s2 to keep the metastable stage isolated
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule : samc_sync

// file: core/samc_top.sv
// mode and supply capability control for an eight channel relay driver
// assumes supply comparators give levels on pins, serial bits from a
// serial block on the same clock
`timescale 1ns/10ps
module samc_top
    import samc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic idle_pin,
    input wire logic [NUM_INPUTS-1:0] direct_input_pins,
    input wire logic vdd_uv,
    input wire logic vdd_at_low_op,
    input wire logic vs_above_3v0,
    input wire logic vs_at_op,
    input wire logic [NUM_CHANNELS-1:0] channel_on_bits,
    input wire logic active_request_bit,
    output logic serial_regs_reset,
    output logic serial_allowed,
    output logic [2:0] sclk_limit_mhz,
    output logic limp_available,
    output samc_mode_t mode,
    output logic [NUM_CHANNELS-1:0] channel_drive
);
    logic idle_lvl;
    logic [NUM_INPUTS-1:0] in_lvl;
    logic dd_uv;
    logic dd_low;
    logic s_ok;
    logic s_op;
    samc_mode_t next_mode;
    logic [3:0] delay_cnt;
    logic [3:0] next_delay_cnt;
    logic [NUM_CHANNELS-1:0] next_channel_drive;
    logic serial_req;
    logic pin_req;
    logic [NUM_CHANNELS-1:0] pin_map;

    // all asynchronous levels pass the three flop filter
    samc_sync u_idle (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin(idle_pin), .level(idle_lvl));
    samc_sync u_in0 (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin(direct_input_pins[0]), .level(in_lvl[0]));
    samc_sync u_in1 (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin(direct_input_pins[1]), .level(in_lvl[1]));
    samc_sync u_dduv (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin(vdd_uv), .level(dd_uv));
    samc_sync u_ddlo (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin(vdd_at_low_op), .level(dd_low));
    samc_sync u_sok (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin(vs_above_3v0), .level(s_ok));
    samc_sync u_sop (.ref_clk(ref_clk), .rst_b(rst_b),
        .pin(vs_at_op), .level(s_op));

    // mapping of pins onto channels, fixed at the default wiring
    function automatic logic [NUM_CHANNELS-1:0] map_pins(
        input logic [NUM_INPUTS-1:0] lv);
        map_pins = (lv[0] ? IN0_DEFAULT_MAP : CHAN_RESET)
                 | (lv[1] ? IN1_DEFAULT_MAP : CHAN_RESET);
    endfunction : map_pins

    // serial capability from the supplies
    always_comb
    begin
        serial_regs_reset = dd_uv || !idle_lvl;
        serial_allowed = !dd_uv;
        if (dd_uv)
            sclk_limit_mhz = SCLK_LIMIT_NONE_MHZ;
        else if (dd_low && !s_op)
            sclk_limit_mhz = SCLK_LIMIT_LOW_MHZ;
        else
            sclk_limit_mhz = SCLK_LIMIT_FULL_MHZ;
        limp_available = !(dd_uv && !s_ok);
    end

    // serial requests only count when serial registers are live
    assign serial_req = !serial_regs_reset
        && (|channel_on_bits || active_request_bit);
    assign pin_map = map_pins(in_lvl);
    assign pin_req = |in_lvl;

    // one counter serves every mode change; a change in mid count restarts
    // it, so a toggling pin only lengthens the dark time, never shortens it
    // mode selection; delay counter holds outputs off after a change
    always_comb
    begin
        next_mode = mode;
        next_delay_cnt = (delay_cnt != 4'h0) ? delay_cnt - 4'h1 : 4'h0;
        if (!idle_lvl)
        begin
            if (pin_req && limp_available)
                next_mode = MODE_LIMP;
            else
                next_mode = MODE_SLEEP;
        end
        else if (serial_req || (pin_req && !dd_uv))
            next_mode = MODE_ACTIVE;
        else
            next_mode = MODE_IDLE;
        if (next_mode != mode)
            next_delay_cnt = MODE_DELAY_CNT;
    end

    // channel drive: serial bits or mapped pins, gated by supplies
    always_comb
    begin
        next_channel_drive = CHAN_RESET;
        if (!s_ok)
            next_channel_drive = CHAN_RESET;
        else if (delay_cnt != 4'h0 || next_mode != mode)
            next_channel_drive = CHAN_RESET;
        else if (mode == MODE_ACTIVE)
            next_channel_drive = (serial_req ? channel_on_bits
                : CHAN_RESET) | pin_map;
        else if (mode == MODE_LIMP)
            next_channel_drive = pin_map;
    end

    // state registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            mode <= MODE_SLEEP;
            delay_cnt <= 4'h0;
            channel_drive <= CHAN_RESET;
        end
        else
        begin
            mode <= next_mode;
            delay_cnt <= next_delay_cnt;
            channel_drive <= next_channel_drive;
        end
    end

    // supply gating checks, all on the filtered levels
    a_chan_off_low_vs: assert property (@(posedge ref_clk) disable iff
        (!rst_b) !s_ok |=> channel_drive == CHAN_RESET)
        else $error("channel driven with analog supply low");
    a_serial_off_uv: assert property (@(posedge ref_clk) disable iff
        (!rst_b) dd_uv |-> !serial_allowed && sclk_limit_mhz == 3'h0
        && serial_regs_reset)
        else $error("serial access while digital supply low");
    a_serial_allowed: assert property (@(posedge ref_clk) disable iff
        (!rst_b) !dd_uv |-> serial_allowed)
        else $error("serial access refused with digital supply valid");
    a_limp_unavail: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (dd_uv && !s_ok) |-> !limp_available)
        else $error("limp home offered with both supplies low");
    a_limp_low_vs: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (!idle_lvl && |in_lvl && !dd_uv && !s_ok)
        |=> mode == MODE_LIMP && channel_drive == CHAN_RESET)
        else $error("limp home wrong with analog supply low");
    a_uv_no_active: assert property (@(posedge ref_clk) disable iff
        (!rst_b) dd_uv |=> mode != MODE_ACTIVE)
        else $error("active mode reached in digital undervoltage");
    a_sclk_low: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (!dd_uv && dd_low && !s_op) |-> sclk_limit_mhz == 3'h1)
        else $error("serial clock ceiling wrong");
    a_full_clock: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (!dd_uv && (!dd_low || s_op))
        |-> sclk_limit_mhz == SCLK_LIMIT_FULL_MHZ)
        else $error("full serial clock ceiling wrong");
    a_regs_reset_idle: assert property (@(posedge ref_clk) disable iff
        (!rst_b) !idle_lvl |-> serial_regs_reset)
        else $error("registers not reset with idle low");
    // mode selection checks
    a_sleep_entry: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (!idle_lvl && in_lvl == 2'h0) |=> mode == MODE_SLEEP)
        else $error("sleep not entered");
    a_limp_entry: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (!idle_lvl && |in_lvl && limp_available)
        |=> mode == MODE_LIMP)
        else $error("limp home not entered");
    a_idle_hold: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (idle_lvl && !dd_uv && channel_on_bits == 8'h00
        && !active_request_bit && in_lvl == 2'h0) |=> mode == MODE_IDLE)
        else $error("idle mode not held");
    a_active_entry: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (idle_lvl && !dd_uv && active_request_bit)
        |=> mode == MODE_ACTIVE)
        else $error("active mode not entered");
    a_pin_active: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (idle_lvl && !dd_uv && |in_lvl)
        |=> mode == MODE_ACTIVE)
        else $error("pin request did not reach active mode");
    // turn-on latency and load gating checks
    a_turnon_delay: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (mode != $past(mode)) |-> channel_drive == CHAN_RESET
        ##1 channel_drive == CHAN_RESET)
        else $error("outputs on before mode delay");
    a_delay_load: assert property (@(posedge ref_clk) disable iff
        (!rst_b) (mode != $past(mode)) |-> delay_cnt == MODE_DELAY_CNT)
        else $error("mode delay not started on a change");
    a_drive_modes: assert property (@(posedge ref_clk) disable iff
        (!rst_b) channel_drive != CHAN_RESET
        |-> mode == MODE_ACTIVE || mode == MODE_LIMP)
        else $error("channel driven outside active or limp home");
    // scenario coverage, each one reached by the bench
    c_active: cover property (@(posedge ref_clk) mode == MODE_ACTIVE
        && channel_drive != 8'h00);
    c_limp: cover property (@(posedge ref_clk) mode == MODE_LIMP
        && channel_drive != 8'h00);
    c_sleep: cover property (@(posedge ref_clk) mode == MODE_SLEEP
        ##1 mode == MODE_IDLE);
    c_pin_active: cover property (@(posedge ref_clk) mode == MODE_ACTIVE
        && channel_drive == IN0_DEFAULT_MAP);
    c_low_vs_limp: cover property (@(posedge ref_clk) mode == MODE_LIMP
        && !s_ok && limp_available);
endmodule : samc_top

// file: sim/samc_mcu.sv
// controller model: drives idle, input pins and serial bits
// assumes the bench calls drive() and reads sclk_mhz
`timescale 1ns/10ps
module samc_mcu
    import samc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [2:0] sclk_limit_mhz,
    output logic idle_pin,
    output logic [NUM_INPUTS-1:0] direct_input_pins,
    output logic [NUM_CHANNELS-1:0] channel_on_bits,
    output logic active_request_bit,
    output logic [2:0] sclk_mhz
);
    localparam logic [2:0] WANT_MHZ = 3'h5;
    // all levels low at power-up, as a sleeping controller would leave them
    initial
    begin
        idle_pin = 1'b0;
        direct_input_pins = '0;
        channel_on_bits = '0;
        active_request_bit = 1'b0;
    end
    // never clock faster than the supplies allow, a low vdd with vs below op needs it slow
    always_comb
        sclk_mhz = (WANT_MHZ > sclk_limit_mhz) ? sclk_limit_mhz
            : WANT_MHZ;
    // new levels land a step after the edge
    task automatic drive(input logic idle, input logic [1:0] inp,
        input logic [7:0] bits, input logic act);
        @(posedge ref_clk);
        #1;
        idle_pin = idle;
        direct_input_pins = inp;
        channel_on_bits = bits;
        active_request_bit = act;
    endtask : drive
endmodule : samc_mcu

// file: sim/supply_aware_mode_control_tb.sv
// bench for the supply aware mode control block
// assumes the controller model drives pins, bench drives supply levels
`timescale 1ns/10ps
module supply_aware_mode_control_tb
    import samc_pkg::*;
;
    logic ref_clk, rst_b, vdd_uv, vdd_at_low_op, vs_above_3v0, vs_at_op;
    logic idle_pin, active_request_bit, serial_regs_reset, serial_allowed;
    logic limp_available;
    logic [1:0] direct_input_pins;
    logic [7:0] channel_on_bits, channel_drive;
    logic [2:0] sclk_limit_mhz, sclk_mhz;
    samc_mode_t mode;
    int error_cnt = 0;
    int n_compared = 0;
    samc_top u_samc_top (.ref_clk(ref_clk), .rst_b(rst_b),
        .idle_pin(idle_pin), .direct_input_pins(direct_input_pins),
        .vdd_uv(vdd_uv), .vdd_at_low_op(vdd_at_low_op),
        .vs_above_3v0(vs_above_3v0), .vs_at_op(vs_at_op),
        .channel_on_bits(channel_on_bits),
        .active_request_bit(active_request_bit),
        .serial_regs_reset(serial_regs_reset),
        .serial_allowed(serial_allowed), .sclk_limit_mhz(sclk_limit_mhz),
        .limp_available(limp_available), .mode(mode),
        .channel_drive(channel_drive));
    samc_mcu u_samc_mcu (.ref_clk(ref_clk), .sclk_limit_mhz(sclk_limit_mhz),
        .idle_pin(idle_pin), .direct_input_pins(direct_input_pins),
        .channel_on_bits(channel_on_bits),
        .active_request_bit(active_request_bit), .sclk_mhz(sclk_mhz));
    // 20 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
        input string what);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : chk
    // supply levels as {uv, low_op, above_3v0, at_op}
    task automatic sup(input logic [3:0] s);
        @(posedge ref_clk);
        #1;
        {vdd_uv, vdd_at_low_op, vs_above_3v0, vs_at_op} = s;
    endtask : sup
    // filter, mode step and turn-on delay take about ten edges
    task automatic settle();
        repeat (14) @(posedge ref_clk);
        #1;
    endtask : settle
    task automatic t_idle();
        u_samc_mcu.drive(1'b1, 2'b00, 8'h00, 1'b0);
        settle();
        chk(8'(mode), 8'(MODE_IDLE), "idle mode");
        chk(8'(serial_regs_reset), 8'h00, "regs kept");
        chk(8'(sclk_limit_mhz), 8'h05, "full clock");
        $display("test idle done");
    endtask : t_idle
    task automatic t_wake();
        u_samc_mcu.drive(1'b1, 2'b00, 8'h81, 1'b0);
        // look a step after each edge, where the registered mode has settled
        for (int i = 0; i < 12 && mode !== MODE_ACTIVE; i++)
        begin
            @(posedge ref_clk);
            #1;
        end
        chk(8'(mode), 8'(MODE_ACTIVE), "wake to active");
        chk(channel_drive, 8'h00, "turn-on held");
        settle();
        chk(channel_drive, 8'h81, "loads on");
        u_samc_mcu.drive(1'b1, 2'b00, 8'h00, 1'b1);
        settle();
        chk(8'(mode), 8'(MODE_ACTIVE), "act bit holds active");
        $display("test wake done");
    endtask : t_wake
    task automatic t_pins();
        u_samc_mcu.drive(1'b0, 2'b00, 8'h00, 1'b0);
        settle();
        chk(8'(mode), 8'(MODE_SLEEP), "sleep");
        chk(8'(serial_regs_reset), 8'h01, "regs reset");
        u_samc_mcu.drive(1'b0, 2'b01, 8'h00, 1'b0);
        settle();
        chk(8'(mode), 8'(MODE_LIMP), "limp");
        chk(channel_drive, IN0_DEFAULT_MAP, "limp drive");
        // idle high with the pin still up: the pin request wakes to active
        u_samc_mcu.drive(1'b1, 2'b01, 8'h00, 1'b0);
        settle();
        chk(8'(mode), 8'(MODE_ACTIVE), "pin to active");
        chk(channel_drive, IN0_DEFAULT_MAP, "pin drive active");
        $display("test pins done");
    endtask : t_pins
    task automatic t_supply();
        sup(4'b1011);
        u_samc_mcu.drive(1'b1, 2'b00, 8'h81, 1'b0);
        settle();
        chk(8'(serial_allowed), 8'h00, "serial refused");
        chk(8'(sclk_limit_mhz), 8'h00, "zero clock");
        chk(8'(serial_regs_reset), 8'h01, "uv regs reset");
        chk(channel_drive, 8'h00, "uv bits ignored");
        sup(4'b0110);
        settle();
        chk(channel_drive, 8'h81, "low band switching");
        chk(8'(sclk_mhz), 8'h01, "slow clock");
        sup(4'b0111);
        settle();
        chk(8'(sclk_mhz), 8'h05, "fast clock");
        sup(4'b0000);
        u_samc_mcu.drive(1'b0, 2'b01, 8'h00, 1'b0);
        settle();
        chk(8'(mode), 8'(MODE_LIMP), "low vs limp");
        chk(8'(limp_available), 8'h01, "low vs limp offered");
        chk(channel_drive, 8'h00, "low vs off");
        sup(4'b1000);
        settle();
        chk(8'(limp_available), 8'h00, "no limp");
        $display("test supply done");
    endtask : t_supply
    task automatic finish_test();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // main sequence, reset held four cycles with supplies healthy
    initial
    begin
        rst_b = 1'b0;
        {vdd_uv, vdd_at_low_op, vs_above_3v0, vs_at_op} = 4'b0011;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_idle();
        t_wake();
        t_pins();
        t_supply();
        finish_test();
    end
    // watchdog: the tests need under two hundred cycles
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end
endmodule : supply_aware_mode_control_tb
